// ===== shared/nfh_pkg.sv
// Constants, timing and types for the flash bus host controller
// Overview of operation
// - Command latched on strobe rise, select low
// - Address latched on strobe rise, select low
// - Neither latch enable high: bytes are data
// - Host may release select during buffer work
// - Low byte carries commands, addresses, data
// - Upper byte low during command, address
// - Host only watches busy until done
`default_nettype none
package nfh_pkg;

	localparam int BUS_WIDTH_DEFAULT = 16;
	localparam int LOW_BYTE = 8;
	localparam logic [15:0] LOW_BYTE_MASK = 16'h00FF;
	localparam int SYNC_STAGES = 2;
	localparam int COUNT_WIDTH = 6;

	localparam int CLOCK_PERIOD_NS = 20;
	localparam int READ_ACCESS_DELAY_NS = 30;
	localparam int STROBE_LOW_NS = 25;
	localparam int STROBE_HIGH_NS = 25;
	localparam int BUSY_SETTLE_NS = 100;

	function automatic int ceilCycles(input int ns);
		int cycles;
		cycles = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
		return (cycles < 1) ? 1 : cycles;
	endfunction

	localparam int READ_ACCESS_CYCLES = ceilCycles(READ_ACCESS_DELAY_NS);
	localparam int STROBE_LOW_CYCLES = ceilCycles(STROBE_LOW_NS);
	localparam int STROBE_HIGH_CYCLES = ceilCycles(STROBE_HIGH_NS);
	localparam int BUSY_SETTLE_CYCLES = ceilCycles(BUSY_SETTLE_NS);
	localparam int READ_LOW_CYCLES = READ_ACCESS_CYCLES + SYNC_STAGES;

	typedef enum logic [1:0] {
		NFH_KIND_CMD = 2'h0,
		NFH_KIND_ADDR = 2'h1,
		NFH_KIND_WDATA = 2'h2,
		NFH_KIND_RDATA = 2'h3
	} nfh_kind_type;

	typedef enum logic [5:0] {
		NFH_IDLE = 6'h01,
		NFH_SETUP = 6'h02,
		NFH_WLOW = 6'h04,
		NFH_RLOW = 6'h08,
		NFH_HOLD = 6'h10,
		NFH_SETTLE = 6'h20
	} nfh_state_type;

endpackage
`default_nettype wire

// ===== design/nfh_host_ctrl.sv
// Host-side controller driving a NAND-style flash over its strobe pins
`timescale 1ns/1ns
`default_nettype none
module nfh_host_ctrl #(
	parameter int BUS_WIDTH = nfh_pkg::BUS_WIDTH_DEFAULT
)(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic reqValid,
	input wire nfh_pkg::nfh_kind_type reqKind,
	input wire logic reqDie,
	input wire logic [BUS_WIDTH-1:0] reqData,
	output logic reqReady,
	output logic rspValid,
	output logic [BUS_WIDTH-1:0] rspData,
	output logic deviceBusy,
	input wire logic writeProtEnable,
	input wire logic autoReadEnable,
	output logic chipSelDie0N,
	output logic chipSelDie1N,
	output logic cmdLatchEn,
	output logic addrLatchEn,
	output logic writeStrobeN,
	output logic readStrobeN,
	output logic writeProtN,
	output logic powerOnReadEn,
	input wire logic readyBusyN,
	input wire logic [BUS_WIDTH-1:0] sharedIoBusIn,
	output logic [BUS_WIDTH-1:0] sharedIoBusOut,
	output logic sharedIoBusOe
);

	localparam logic [BUS_WIDTH-1:0] LOW_MASK = BUS_WIDTH'(nfh_pkg::LOW_BYTE_MASK);
	localparam logic [nfh_pkg::COUNT_WIDTH-1:0] WLOW_LAST =
		nfh_pkg::COUNT_WIDTH'(nfh_pkg::STROBE_LOW_CYCLES - 1);
	localparam logic [nfh_pkg::COUNT_WIDTH-1:0] HOLD_LAST =
		nfh_pkg::COUNT_WIDTH'(nfh_pkg::STROBE_HIGH_CYCLES - 1);
	localparam logic [nfh_pkg::COUNT_WIDTH-1:0] RLOW_LAST =
		nfh_pkg::COUNT_WIDTH'(nfh_pkg::READ_LOW_CYCLES - 1);
	localparam logic [nfh_pkg::COUNT_WIDTH-1:0] SETTLE_LAST =
		nfh_pkg::COUNT_WIDTH'(nfh_pkg::BUSY_SETTLE_CYCLES - 1);
	localparam logic [nfh_pkg::COUNT_WIDTH-1:0] READ_LOW_COUNT =
		nfh_pkg::COUNT_WIDTH'(nfh_pkg::READ_LOW_CYCLES);
	localparam int READ_ANSWER_DELAY = nfh_pkg::READ_LOW_CYCLES;

	if (BUS_WIDTH != nfh_pkg::LOW_BYTE && BUS_WIDTH != 2 * nfh_pkg::LOW_BYTE)
		$error("BUS_WIDTH must be 8 or 16");
	if (nfh_pkg::BUSY_SETTLE_CYCLES >= (1 << nfh_pkg::COUNT_WIDTH)
		|| nfh_pkg::READ_LOW_CYCLES >= (1 << nfh_pkg::COUNT_WIDTH))
		$error("Timing counts exceed counter width");

	function automatic logic isCmdOrAddr(input nfh_pkg::nfh_kind_type kind);
		return kind == nfh_pkg::NFH_KIND_CMD || kind == nfh_pkg::NFH_KIND_ADDR;
	endfunction

	nfh_pkg::nfh_state_type state, next_state;
	nfh_pkg::nfh_kind_type kind, next_kind;
	logic [nfh_pkg::COUNT_WIDTH-1:0] count, next_count;
	logic die, next_die;
	logic selActive, next_selActive;
	logic next_cmdLatchEn, next_addrLatchEn, next_writeStrobeN, next_readStrobeN;
	logic next_writeProtN, next_powerOnReadEn, next_sharedIoBusOe, next_rspValid;
	logic [BUS_WIDTH-1:0] next_sharedIoBusOut, next_rspData;
	logic rbSync1, rbSync2, next_rbSync1, next_rbSync2;
	logic [BUS_WIDTH-1:0] ioSync1, ioSync2, next_ioSync1, next_ioSync2;

	// Deselected whenever idle, so the device may idle down or keep working
	assign chipSelDie0N = !(selActive && !die);
	assign chipSelDie1N = !(selActive && die);
	assign deviceBusy = !rbSync2;
	// New work only once the busy line has been released
	assign reqReady = (state == nfh_pkg::NFH_IDLE) && rbSync2;

	always_comb
	begin
		next_state = state;
		next_kind = kind;
		next_count = count;
		next_die = die;
		next_selActive = selActive;
		next_cmdLatchEn = cmdLatchEn;
		next_addrLatchEn = addrLatchEn;
		next_writeStrobeN = writeStrobeN;
		next_readStrobeN = readStrobeN;
		next_sharedIoBusOut = sharedIoBusOut;
		next_sharedIoBusOe = sharedIoBusOe;
		next_rspData = rspData;
		next_rspValid = 1'b0;
		next_writeProtN = !writeProtEnable;
		next_powerOnReadEn = autoReadEnable;
		next_rbSync1 = readyBusyN;
		next_rbSync2 = rbSync1;
		next_ioSync1 = sharedIoBusIn;
		next_ioSync2 = ioSync1;
		unique case (state)
			nfh_pkg::NFH_IDLE:
			begin
				if (reqValid && reqReady)
				begin
					next_kind = reqKind;
					next_die = reqDie;
					next_selActive = 1'b1;
					next_count = '0;
					// Latch enables are mutually exclusive by construction
					next_cmdLatchEn = (reqKind == nfh_pkg::NFH_KIND_CMD);
					next_addrLatchEn = (reqKind == nfh_pkg::NFH_KIND_ADDR);
					next_sharedIoBusOe = (reqKind != nfh_pkg::NFH_KIND_RDATA);
					// Commands and addresses ride the low byte only
					next_sharedIoBusOut = isCmdOrAddr(reqKind) ? (reqData & LOW_MASK) : reqData;
					next_state = nfh_pkg::NFH_SETUP;
				end
			end
			nfh_pkg::NFH_SETUP:
			begin
				if (kind == nfh_pkg::NFH_KIND_RDATA)
				begin
					next_readStrobeN = 1'b0;
					next_state = nfh_pkg::NFH_RLOW;
				end
				else
				begin
					next_writeStrobeN = 1'b0;
					next_state = nfh_pkg::NFH_WLOW;
				end
			end
			nfh_pkg::NFH_WLOW:
			begin
				next_count = count + 1'b1;
				if (count == WLOW_LAST)
				begin
					// Rising edge is where the device captures the bus
					next_writeStrobeN = 1'b1;
					next_count = '0;
					next_state = nfh_pkg::NFH_HOLD;
				end
			end
			nfh_pkg::NFH_RLOW:
			begin
				next_count = count + 1'b1;
				if (count == RLOW_LAST)
				begin
					// Access delay plus synchroniser latency have elapsed
					next_rspData = ioSync2;
					next_rspValid = 1'b1;
					next_readStrobeN = 1'b1;
					next_count = '0;
					next_state = nfh_pkg::NFH_HOLD;
				end
			end
			nfh_pkg::NFH_HOLD:
			begin
				next_count = count + 1'b1;
				if (count == HOLD_LAST)
				begin
					next_cmdLatchEn = 1'b0;
					next_addrLatchEn = 1'b0;
					next_sharedIoBusOe = 1'b0;
					next_selActive = 1'b0;
					next_count = '0;
					// Give the device time to pull busy after a command
					next_state = (kind == nfh_pkg::NFH_KIND_CMD) ? nfh_pkg::NFH_SETTLE : nfh_pkg::NFH_IDLE;
				end
			end
			nfh_pkg::NFH_SETTLE:
			begin
				next_count = count + 1'b1;
				if (count == SETTLE_LAST)
				begin
					next_count = '0;
					next_state = nfh_pkg::NFH_IDLE;
				end
			end
			default:
			begin
				next_state = nfh_pkg::NFH_IDLE;
				next_selActive = 1'b0;
				next_writeStrobeN = 1'b1;
				next_readStrobeN = 1'b1;
				next_sharedIoBusOe = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= nfh_pkg::NFH_IDLE;
			kind <= nfh_pkg::NFH_KIND_CMD;
			count <= '0;
			die <= 1'b0;
			selActive <= 1'b0;
			cmdLatchEn <= 1'b0;
			addrLatchEn <= 1'b0;
			writeStrobeN <= 1'b1;
			readStrobeN <= 1'b1;
			writeProtN <= 1'b0;
			powerOnReadEn <= 1'b0;
			sharedIoBusOut <= '0;
			sharedIoBusOe <= 1'b0;
			rspData <= '0;
			rspValid <= 1'b0;
			rbSync1 <= 1'b0;
			rbSync2 <= 1'b0;
			ioSync1 <= '0;
			ioSync2 <= '0;
		end
		else
		begin
			state <= next_state;
			kind <= next_kind;
			count <= next_count;
			die <= next_die;
			selActive <= next_selActive;
			cmdLatchEn <= next_cmdLatchEn;
			addrLatchEn <= next_addrLatchEn;
			writeStrobeN <= next_writeStrobeN;
			readStrobeN <= next_readStrobeN;
			writeProtN <= next_writeProtN;
			powerOnReadEn <= next_powerOnReadEn;
			sharedIoBusOut <= next_sharedIoBusOut;
			sharedIoBusOe <= next_sharedIoBusOe;
			rspData <= next_rspData;
			rspValid <= next_rspValid;
			rbSync1 <= next_rbSync1;
			rbSync2 <= next_rbSync2;
			ioSync1 <= next_ioSync1;
			ioSync2 <= next_ioSync2;
		end
	end

	// Length of the current read strobe low phase
	logic [nfh_pkg::COUNT_WIDTH-1:0] readLowCount;
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
			readLowCount <= '0;
		else if (readStrobeN)
			readLowCount <= '0;
		else
			readLowCount <= readLowCount + 1'b1;
	end

	default clocking assertClk @(posedge mclk); endclocking
	default disable iff (!rst_n);

	latch_excl_a: assert property (!(cmdLatchEn && addrLatchEn))
		else $error("Both latch enables high");
	cmd_capture_a: assert property ($rose(writeStrobeN) && cmdLatchEn |-> (!chipSelDie0N || !chipSelDie1N))
		else $error("Command strobe without chip select");
	addr_capture_a: assert property ($rose(writeStrobeN) && addrLatchEn |-> (!chipSelDie0N || !chipSelDie1N) && sharedIoBusOe)
		else $error("Address strobe without select or drive");
	data_capture_a: assert property ($rose(writeStrobeN) && !cmdLatchEn && !addrLatchEn |-> sharedIoBusOe && (!chipSelDie0N || !chipSelDie1N))
		else $error("Data strobe without drive or select");
	upper_byte_a: assert property (sharedIoBusOe && (cmdLatchEn || addrLatchEn) |-> (sharedIoBusOut & ~LOW_MASK) == '0)
		else $error("Upper byte not low on command or address");
	read_length_a: assert property ($rose(readStrobeN) |-> $past(readLowCount) == READ_LOW_COUNT - 1'b1)
		else $error("Read strobe low phase has wrong length");
	read_answer_a: assert property ($fell(readStrobeN) |-> ##READ_ANSWER_DELAY rspValid && readStrobeN)
		else $error("Read answer not at strobe release");
	busy_hold_a: assert property (state == nfh_pkg::NFH_IDLE && !rbSync2 |=> state == nfh_pkg::NFH_IDLE)
		else $error("Left idle while device busy");
	idle_desel_a: assert property (state == nfh_pkg::NFH_IDLE && $past(state) == nfh_pkg::NFH_IDLE |-> chipSelDie0N && chipSelDie1N)
		else $error("Chip select active while idle");

endmodule
`default_nettype wire

// ===== bench/nfh_dev_model.sv
// Behavioural flash device on the far side of the host controller
`timescale 1ns/1ns
`default_nettype none
module nfh_dev_model #(
	parameter int ACCESS_NS = 30,
	parameter int PROG_NS = 600,
	parameter int AUTO_NS = 200,
	parameter logic [7:0] START_CMD = 8'h10
)(
	input wire logic chipSelN,
	input wire logic cmdLatchEn,
	input wire logic addrLatchEn,
	input wire logic writeStrobeN,
	input wire logic readStrobeN,
	input wire logic writeProtN,
	input wire logic powerOnReadEn,
	input wire logic [15:0] busLine,
	output logic [15:0] devIo,
	output logic busyPull,
	output logic [7:0] cmdReg,
	output logic [7:0] upperSeen,
	output logic [15:0] dataReg,
	output logic standby
);
	logic [7:0] column;
	logic [15:0] word;
	initial
	begin
		devIo = 16'h0000;
		busyPull = 1'b0;
		cmdReg = 8'h00;
		upperSeen = 8'hEE;
		dataReg = 16'h0000;
		column = 8'h33;
	end
	task automatic holdBusy(input int ns);
		busyPull = 1'b1;
		fork
			#ns busyPull = 1'b0;
		join_none
	endtask
	// Pulled low while busy or while the chip is selected
	assign standby = chipSelN && !busyPull;
	always @(posedge writeStrobeN)
	begin
		if (!chipSelN && cmdLatchEn)
		begin
			cmdReg = busLine[7:0];
			upperSeen = busLine[15:8];
			if (busLine[7:0] == START_CMD && writeProtN)
				holdBusy(PROG_NS);
		end
		else if (!chipSelN && addrLatchEn)
		begin
			column = busLine[7:0];
			upperSeen = busLine[15:8];
		end
		else if (!chipSelN)
			dataReg = busLine;
	end
	always @(negedge readStrobeN)
	begin
		if (!chipSelN)
		begin
			word = {column ^ 8'h5A, column};
			column = column + 8'h01;
			#ACCESS_NS devIo = word;
		end
	end
	// Released bus shows the inverse, not a stale word
	always @(posedge readStrobeN)
	begin
		#10 devIo = ~devIo;
	end
	always @(posedge powerOnReadEn)
	begin
		column = 8'h00;
		holdBusy(AUTO_NS);
	end
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Testbench of the flash host controller against the device model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b, m) begin nTests++; if ((a) !== (b)) begin mismatches++; $display("BAD %0t %s", $time, m); end end
module tb;
	logic mclk, rst_n, reqValid, reqDie, writeProtEnable, autoReadEnable;
	nfh_pkg::nfh_kind_type reqKind;
	logic [15:0] reqData, rspData, ioOut, devIo, dataReg;
	logic reqReady, rspValid, deviceBusy, sel0N, sel1N, cle, ale, wsN, rsN, wpN, porEn, ioOe, busyPull, standby;
	logic [7:0] cmdReg, upperSeen;
	wire readyBusyN;
	wire [15:0] busLine;
	int mismatches = 0;
	int nTests = 0;
	logic busySeen = 1'b0;
	logic sel1Seen = 1'b0;
	int busyAge = 0;
	assign readyBusyN = busyPull ? 1'b0 : 1'b1;
	assign busLine = ioOe ? ioOut : devIo;
	nfh_host_ctrl nfh_host_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .reqValid(reqValid), .reqKind(reqKind),
		.reqDie(reqDie), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData),
		.deviceBusy(deviceBusy), .writeProtEnable(writeProtEnable), .autoReadEnable(autoReadEnable),
		.chipSelDie0N(sel0N), .chipSelDie1N(sel1N), .cmdLatchEn(cle), .addrLatchEn(ale), .writeStrobeN(wsN),
		.readStrobeN(rsN), .writeProtN(wpN), .powerOnReadEn(porEn), .readyBusyN(readyBusyN),
		.sharedIoBusIn(busLine), .sharedIoBusOut(ioOut), .sharedIoBusOe(ioOe));
	nfh_dev_model nfh_dev_model_inst (.chipSelN(sel0N), .cmdLatchEn(cle), .addrLatchEn(ale), .writeStrobeN(wsN),
		.readStrobeN(rsN), .writeProtN(wpN), .powerOnReadEn(porEn), .busLine(busLine), .devIo(devIo),
		.busyPull(busyPull), .cmdReg(cmdReg), .upperSeen(upperSeen), .dataReg(dataReg), .standby(standby));
	always #10 mclk = ~mclk;
	always @(posedge mclk)
	begin
		if (deviceBusy === 1'b1)
			busySeen <= 1'b1;
		if (sel1N === 1'b0)
			sel1Seen <= 1'b1;
		// Cycles the raw busy line has been low; strobes must stay idle once it passes 2
		busyAge <= (readyBusyN === 1'b0) ? busyAge + 1 : 0;
		if (rst_n && ((deviceBusy === 1'b1 && reqReady !== 1'b0) || (cle && ale)
			|| (busyAge > 2 && (wsN === 1'b0 || rsN === 1'b0))))
		begin
			mismatches++;
			$display("BAD %0t host active while busy or both latches", $time);
		end
	end
	function automatic logic [15:0] page(input logic [7:0] c);
		return {c ^ 8'h5A, c};
	endfunction
	task automatic waitReady();
		int i;
		i = 0;
		while (reqReady !== 1'b1 && i < 200)
		begin
			@(negedge mclk);
			i++;
		end
		`CHK(reqReady, 1'b1, "ready wait")
	endtask
	task automatic send(input nfh_pkg::nfh_kind_type k, input logic d, input logic [15:0] v, input logic [15:0] e);
		int i;
		waitReady();
		reqKind = k;
		reqDie = d;
		reqData = v;
		reqValid = 1'b1;
		@(negedge mclk);
		reqValid = 1'b0;
		i = 0;
		while (k == nfh_pkg::NFH_KIND_RDATA && rspValid !== 1'b1 && i < 20)
		begin
			@(negedge mclk);
			i++;
		end
		if (k == nfh_pkg::NFH_KIND_RDATA)
			`CHK(rspData, e, "read word")
		@(negedge mclk);
		if (k == nfh_pkg::NFH_KIND_RDATA)
			`CHK(rspValid, 1'b0, "answer pulse")
		waitReady();
	endtask
	task automatic t_power();
		int i;
		i = 0;
		while (busyPull !== 1'b1 && i < 10)
		begin
			@(negedge mclk);
			i++;
		end
		repeat (3) @(negedge mclk);
		`CHK(deviceBusy, 1'b1, "auto-read busy")
		`CHK(standby, 1'b0, "standby while busy")
		for (i = 0; i < 3; i++)
			send(nfh_pkg::NFH_KIND_RDATA, 1'b0, 16'h0000, page(i[7:0]));
		$display("done power-on read");
	endtask
	task automatic t_cmd();
		send(nfh_pkg::NFH_KIND_CMD, 1'b1, 16'hAB30, 16'h0000);
		`CHK(cmdReg, 8'h00, "other die latched")
		`CHK(sel1Seen, 1'b1, "die 1 select")
		send(nfh_pkg::NFH_KIND_CMD, 1'b0, 16'hAB30, 16'h0000);
		`CHK(cmdReg, 8'h30, "command byte")
		`CHK(upperSeen, 8'h00, "upper byte on command")
		send(nfh_pkg::NFH_KIND_ADDR, 1'b0, 16'hFF07, 16'h0000);
		`CHK(upperSeen, 8'h00, "upper byte on address")
		send(nfh_pkg::NFH_KIND_RDATA, 1'b0, 16'h0000, page(8'h07));
		send(nfh_pkg::NFH_KIND_RDATA, 1'b0, 16'h0000, page(8'h08));
		send(nfh_pkg::NFH_KIND_WDATA, 1'b0, 16'hC3E1, 16'h0000);
		`CHK(dataReg, 16'hC3E1, "write data")
		`CHK(standby, 1'b1, "standby when idle")
		$display("done command address data");
	endtask
	task automatic t_protect();
		writeProtEnable = 1'b1;
		busySeen = 1'b0;
		send(nfh_pkg::NFH_KIND_CMD, 1'b0, 16'h0010, 16'h0000);
		`CHK(wpN, 1'b0, "protect pin")
		`CHK(busySeen, 1'b0, "protected start")
		writeProtEnable = 1'b0;
		send(nfh_pkg::NFH_KIND_CMD, 1'b0, 16'h0010, 16'h0000);
		`CHK(busySeen, 1'b1, "program busy")
		$display("done write protect");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", nTests, mismatches);
		if (mismatches == 0 && nTests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		mclk = 1'b0;
		rst_n = 1'b0;
		reqValid = 1'b0;
		reqKind = nfh_pkg::NFH_KIND_CMD;
		reqDie = 1'b0;
		reqData = 16'h0000;
		writeProtEnable = 1'b0;
		autoReadEnable = 1'b1;
		repeat (3) @(negedge mclk);
		rst_n = 1'b1;
		`CHK(sel0N, 1'b1, "select idle")
		t_power();
		t_cmd();
		t_protect();
		final_report();
	end
	initial
	begin
		#100000;
		mismatches++;
		$display("BAD %0t watchdog", $time);
		final_report();
	end
endmodule
`default_nettype wire
